/* include/tsg_pkg.sv */
package tsg_pkg;
   // long-mode task_state_segment layout, dword index = byte offset / 4
   localparam int          TSG_WORDS         = 26;
   localparam logic [6:0]  TSG_SP_FIRST_OFS  = 7'h04;
   localparam logic [6:0]  TSG_SP_LAST_OFS   = 7'h1b;
   localparam logic [6:0]  TSG_IST_FIRST_OFS = 7'h24;
   localparam logic [6:0]  TSG_IST_LAST_OFS  = 7'h5b;
   localparam logic [6:0]  TSG_IO_PERMISSION_BITMAP_OFS      = 7'h64;
   localparam logic [4:0]  TSG_SP_FIRST_IDX  = 5'h01;
   localparam logic [4:0]  TSG_IST_FIRST_IDX = 5'h09;
   localparam logic [4:0]  TSG_IO_PERMISSION_BITMAP_IDX      = 5'h19;
   localparam int          TSG_IO_PERMISSION_BITMAP_LSB      = 16;
   localparam int          TSG_SP_LEVELS     = 3;
   localparam int          TSG_IST_COUNT     = 7;
   localparam logic [31:0] TSG_RST_WORD      = 32'h0;
   // gate descriptor fields, bit positions in the 64-bit descriptor
   localparam int          TSG_SEL_LSB       = 16;
   localparam int          TSG_TYPE_LSB      = 40;
   localparam int          TSG_S_BIT         = 44;
   localparam int          TSG_DPL_LSB       = 45;
   localparam int          TSG_P_BIT         = 47;
   localparam logic [4:0]  TSG_TASK_GATE     = 5'h05;
   // busy flag inside the type field of a segment descriptor
   localparam int          TSG_BUSY_BIT      = 41;
   localparam logic [15:0] TSG_RST_SEL       = 16'h0;
   localparam logic [63:0] TSG_RST_DESC      = 64'h0;
endpackage : tsg_pkg

/* src/tsg_gate_dec.sv */
`timescale 1ns/10ps
module tsg_gate_dec
   import tsg_pkg::*;
(
   input  wire logic [63:0] desc,
   output wire logic        is_task,
   output wire logic        present,
   output wire logic [1:0]  gate_privilege_level,
   output wire logic [15:0] selector
);
   wire logic [4:0] s_type;

   assign s_type   = desc[TSG_S_BIT:TSG_TYPE_LSB];
   assign is_task  = (s_type == TSG_TASK_GATE);                // [RULE10]
   // present flag is only observed here, never written back
   assign present  = desc[TSG_P_BIT];                          // [RULE12]
   assign gate_privilege_level      = desc[TSG_DPL_LSB+1:TSG_DPL_LSB];          // [RULE13]
   // reserved bits of both dwords are left unread
   assign selector = desc[TSG_SEL_LSB+15:TSG_SEL_LSB];         // [RULE15]
endmodule : tsg_gate_dec

/* src/tsg_decode.sv */
`timescale 1ns/10ps
// What this block does
// [RULE1] no hardware task switch in long mode; such requests are refused
// [RULE2] software builds a 64-bit segment before long mode is used
// [RULE3] task register load accepted in long mode only from 64-bit mode
// [RULE4] no register-save fields exist or are used in the 64-bit segment
// [RULE5] software saves and restores its own multitasking state
// [RULE6] privilege stack pointers 0..2 read as 64-bit from bytes 04h-1Bh
// [RULE7] seven stack-table pointers read as 64-bit from bytes 24h-5Bh
// [RULE8] 16-bit io bitmap base taken from bytes 66h-67h
// [RULE9] task gates accepted from global, local or interrupt tables
// [RULE10] task gate identified when system bit and type equal 00101b
// [RULE11] not-present fault when a referenced descriptor has present clear
// [RULE12] present flag is written by software only, never by this block
// [RULE13] gate privilege level from bits 14:13 of upper dword
// [RULE14] task register load stores descriptor, marks busy, no switch
// [RULE15] gate selector from bits 31:16 of lower dword, reserved ignored
// [RULE16] reserved areas of the segment, 00h-03h and 1Ch-23h, ignored
module tsg_decode
   import tsg_pkg::*;
#(
   parameter int NUM_IST = TSG_IST_COUNT
)
(
   input  wire logic        REF_CLK,
   input  wire logic        SRST,
   input  wire logic        CE,
   input  wire logic        LONG_MODE,
   input  wire logic        MODE64,
   input  wire logic        TSS_WR_VALID,
   input  wire logic [6:0]  TSS_WR_OFFSET,
   input  wire logic [31:0] TSS_WR_DATA,
   input  wire logic [1:0]  SP_SEL,
   input  wire logic [2:0]  IST_SEL,
   input  wire logic        LTR_VALID,
   input  wire logic [15:0] LTR_SELECTOR,
   input  wire logic [63:0] LTR_DESC,
   input  wire logic        TASK_SWITCH_REQ,
   input  wire logic        GATE_VALID,
   input  wire logic [1:0]  GATE_TABLE,
   input  wire logic [63:0] GATE_DESC,
   output logic [63:0]      PRIV_SP,
   output logic [63:0]      IST_PTR,
   output logic [15:0]      IO_PERMISSION_BITMAP_BASE,
   output logic [15:0]      TR_SELECTOR,
   output logic [63:0]      TR_DESC,
   output logic             TR_BUSY,
   output logic             LTR_FAULT,
   output logic             TS_ACCEPT,
   output logic             TS_REFUSED,
   output logic             GATE_DONE,
   output logic             GATE_IS_TASK,
   output logic             GATE_PRESENT,
   output logic [1:0]       GATE_DPL,
   output logic [15:0]      GATE_SELECTOR,
   output logic [1:0]       GATE_TABLE_OUT,
   output logic             GATE_TASK_SWITCH,
   output logic             NP_FAULT
);
   import tsg_pkg::*;

   if (NUM_IST < 1 || NUM_IST > TSG_IST_COUNT)
   begin : g_bad_ist
      $error("NUM_IST must lie in 1..7");
   end

   localparam logic [3:0] IST_MAX = 4'(NUM_IST);

   // shadow of the processor-used dwords of the segment
   logic [31:0] mem_q [TSG_WORDS];

   function automatic logic ofs_used(input logic [6:0] ofs);
      ofs_used = ((ofs >= TSG_SP_FIRST_OFS) && (ofs <= TSG_SP_LAST_OFS)) ||
                 ((ofs >= TSG_IST_FIRST_OFS) && (ofs <= TSG_IST_LAST_OFS)) ||
                 (ofs == TSG_IO_PERMISSION_BITMAP_OFS);
   endfunction : ofs_used

   wire logic [4:0]  wr_idx;
   wire logic        wr_ok;
   wire logic [4:0]  sp_idx;
   wire logic [4:0]  ist_idx;
   wire logic        sp_ok;
   wire logic        ist_ok;
   wire logic [63:0] sp_next;
   wire logic [63:0] ist_next;
   wire logic        ltr_ok;
   wire logic        ltr_bad;
   wire logic        dec_task;
   wire logic        dec_present;
   wire logic [1:0]  dec_dpl;
   wire logic [15:0] dec_sel;
   wire logic [15:0] io_permission_bitmap_next;

   assign wr_idx = TSS_WR_OFFSET[6:2];
   // legacy save areas and reserved dwords are dropped on write
   assign wr_ok  = TSS_WR_VALID && (TSS_WR_OFFSET[1:0] == 2'h0) &&
                   ofs_used(TSS_WR_OFFSET);          // [RULE4] [RULE16]

   assign sp_idx   = 5'(TSG_SP_FIRST_IDX + {2'h0, SP_SEL, 1'b0});
   assign ist_idx  = 5'(TSG_IST_FIRST_IDX + {1'b0, IST_SEL, 1'b0});
   assign sp_ok    = ({30'h0, SP_SEL} < TSG_SP_LEVELS);
   assign ist_ok   = ({1'b0, IST_SEL} < IST_MAX);
   assign sp_next  = sp_ok ? {mem_q[sp_idx + 5'h01], mem_q[sp_idx]}
                           : 64'h0;                          // [RULE6]
   assign ist_next = ist_ok ? {mem_q[ist_idx + 5'h01], mem_q[ist_idx]}
                            : 64'h0;                         // [RULE7]
   assign io_permission_bitmap_next = mem_q[TSG_IO_PERMISSION_BITMAP_IDX][TSG_IO_PERMISSION_BITMAP_LSB+15:TSG_IO_PERMISSION_BITMAP_LSB]; // [RULE8]

   // in long mode the load must come from 64-bit code
   assign ltr_bad = LTR_VALID && LONG_MODE && !MODE64;       // [RULE3]
   assign ltr_ok  = LTR_VALID && !ltr_bad;

   tsg_gate_dec u_gate_dec
   (
      .desc     (GATE_DESC),
      .is_task  (dec_task),
      .present  (dec_present),
      .gate_privilege_level      (dec_dpl),
      .selector (dec_sel)
   );

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         for (int i = 0; i < TSG_WORDS; i++)
         begin
            mem_q[i] <= TSG_RST_WORD;
         end
      end
      else if (CE && wr_ok)
      begin
         mem_q[wr_idx] <= TSS_WR_DATA;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         PRIV_SP   <= 64'h0;
         IST_PTR   <= 64'h0;
         IO_PERMISSION_BITMAP_BASE <= 16'h0;
      end
      else if (CE)
      begin
         PRIV_SP   <= sp_next;
         IST_PTR   <= ist_next;
         IO_PERMISSION_BITMAP_BASE <= io_permission_bitmap_next;
      end
   end

   // descriptor stored with busy set; segment shadow left untouched
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         TR_SELECTOR <= TSG_RST_SEL;
         TR_DESC     <= TSG_RST_DESC;
         TR_BUSY     <= 1'b0;
         LTR_FAULT   <= 1'b0;
      end
      else if (CE)
      begin
         LTR_FAULT <= ltr_bad;
         if (ltr_ok)
         begin
            TR_SELECTOR <= LTR_SELECTOR;                      // [RULE14]
            TR_DESC     <= LTR_DESC | (64'h1 << TSG_BUSY_BIT);
            TR_BUSY     <= 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         TS_ACCEPT  <= 1'b0;
         TS_REFUSED <= 1'b0;
      end
      else if (CE)
      begin
         TS_ACCEPT  <= TASK_SWITCH_REQ && !LONG_MODE;         // [RULE1]
         TS_REFUSED <= TASK_SWITCH_REQ && LONG_MODE;
      end
   end

   // any table is fine for a task gate, so the table is only echoed
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         GATE_DONE        <= 1'b0;
         GATE_IS_TASK     <= 1'b0;
         GATE_PRESENT     <= 1'b0;
         GATE_DPL         <= 2'h0;
         GATE_SELECTOR    <= 16'h0;
         GATE_TABLE_OUT   <= 2'h0;
         GATE_TASK_SWITCH <= 1'b0;
         NP_FAULT         <= 1'b0;
      end
      else if (CE)
      begin
         GATE_DONE        <= GATE_VALID;
         GATE_TASK_SWITCH <= GATE_VALID && dec_task && dec_present &&
                             !LONG_MODE;                      // [RULE9]
         NP_FAULT         <= GATE_VALID && !dec_present;      // [RULE11]
         if (GATE_VALID)
         begin
            GATE_IS_TASK   <= dec_task;
            GATE_PRESENT   <= dec_present;
            GATE_DPL       <= dec_dpl;
            GATE_SELECTOR  <= dec_sel;
            GATE_TABLE_OUT <= GATE_TABLE;
         end
      end
   end

   default clocking cb_ref @(posedge REF_CLK);
   endclocking
   default disable iff (SRST);

   sequence s_sp0_write;
      CE && TSS_WR_VALID && (TSS_WR_OFFSET == 7'h04) ##1
      CE && !TSS_WR_VALID && (SP_SEL == 2'h0);
   endsequence

   sequence s_ist1_write;
      CE && TSS_WR_VALID && (TSS_WR_OFFSET == 7'h28) ##1
      CE && !TSS_WR_VALID && (IST_SEL == 3'h0);
   endsequence

   sequence s_io_permission_bitmap_write;
      CE && TSS_WR_VALID && (TSS_WR_OFFSET == 7'h64) ##1
      CE && !TSS_WR_VALID;
   endsequence

   a_ts_refused_long: assert property ( // [RULE1]
      CE && TASK_SWITCH_REQ && LONG_MODE |=> TS_REFUSED && !TS_ACCEPT)
      else $error("task switch not refused in long mode");

   a_ltr_mode_check: assert property ( // [RULE3]
      CE && LTR_VALID && LONG_MODE && !MODE64 |=>
      LTR_FAULT && $stable(TR_SELECTOR) && $stable(TR_DESC))
      else $error("task register load from wrong mode not refused");

   a_ltr_busy_mark: assert property ( // [RULE14]
      CE && LTR_VALID && (MODE64 || !LONG_MODE) |=>
      TR_BUSY && (TR_SELECTOR == $past(LTR_SELECTOR)) &&
      TR_DESC[TSG_BUSY_BIT] && !LTR_FAULT)
      else $error("task register load not stored busy");

   a_sp0_readback: assert property ( // [RULE6]
      s_sp0_write |=> PRIV_SP[31:0] == $past(TSS_WR_DATA, 2))
      else $error("stack pointer 0 low dword wrong");

   a_ist1_readback: assert property ( // [RULE7]
      s_ist1_write |=> IST_PTR[63:32] == $past(TSS_WR_DATA, 2))
      else $error("stack table pointer 1 high dword wrong");

   a_io_permission_bitmap_base: assert property ( // [RULE8]
      s_io_permission_bitmap_write |=> IO_PERMISSION_BITMAP_BASE == $past(TSS_WR_DATA[31:16], 2))
      else $error("io bitmap base wrong");

   a_reserved_drop: assert property ( // [RULE16]
      CE && TSS_WR_VALID && (TSS_WR_OFFSET == 7'h1c) |=> $stable(mem_q[7]))
      else $error("reserved dword written");

   a_gate_type_dpl: assert property ( // [RULE10]
      CE && GATE_VALID |=>
      (GATE_IS_TASK ==
       ($past(GATE_DESC[TSG_S_BIT:TSG_TYPE_LSB]) == TSG_TASK_GATE)) &&
      (GATE_DPL == $past(GATE_DESC[TSG_DPL_LSB+1:TSG_DPL_LSB])))
      else $error("gate type or privilege decode wrong");

   a_gate_np_fault: assert property ( // [RULE11]
      CE && GATE_VALID |=> NP_FAULT == !$past(GATE_DESC[TSG_P_BIT]))
      else $error("not-present fault wrong");

   a_np_fault_idle: assert property ( // [RULE11]
      CE && !GATE_VALID |=> !NP_FAULT)
      else $error("not-present fault without a gate request");

   a_gate_selector: assert property ( // [RULE15]
      CE && GATE_VALID |=> GATE_SELECTOR == $past(GATE_DESC[31:16]))
      else $error("gate selector wrong");
endmodule : tsg_decode

/* sim/tsg_mem_model.sv */
`timescale 1ns/10ps
module tsg_mem_model
(
   input  wire logic        clk,
   input  wire logic        start,
   output logic             wr_valid,
   output logic [6:0]       wr_offset,
   output logic [31:0]      wr_data,
   output logic             busy
);
   logic [31:0] img [0:25];
   initial
   begin
      {wr_valid, wr_offset, wr_data, busy} = '0;
   end
   // software writes the whole image, sometimes with idle gaps
   always @(posedge start)
   begin : fill
      int i;
      busy = 1'b1;
      for (i = 0; i < 26; i++)
      begin
         img[i] = $urandom;
         if ($urandom_range(1, 0) == 1)
         begin
            wr_valid  = 1'b0;
            wr_offset = ~wr_offset;
            wr_data   = ~wr_data;
            @(negedge clk);
         end
         wr_valid  = 1'b1;
         wr_offset = 7'(i * 4);
         wr_data   = img[i];
         @(negedge clk);
      end
      wr_valid  = 1'b0;
      wr_offset = ~wr_offset;
      wr_data   = ~wr_data;
      busy      = 1'b0;
   end
endmodule : tsg_mem_model

/* sim/tsg_decode_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin fails++; \
   $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end
module tsg_decode_tb import tsg_pkg::*;;
   typedef logic [27:0] tsg_ev_t;
   localparam int NI = 7;
   logic        ref_clk, srst, ce, long_mode, mode64, ltr_valid, ts_req;
   logic        gate_valid, start, mem_busy, wr_valid, armed, eb;
   logic [1:0]  sp_sel, gate_table, gate_dpl, gate_table_out;
   logic [2:0]  ist_sel;
   logic [6:0]  wr_offset;
   logic [15:0] ltr_sel, io_permission_bitmap_base, tr_selector, gate_selector, es;
   logic [31:0] wr_data;
   logic [63:0] ltr_desc, gate_desc, priv_sp, ist_ptr, tr_desc, ed, d;
   logic        tr_busy, ltr_fault, ts_accept, ts_refused, gate_done;
   logic        gate_is_task, gate_present, gate_task_switch, np_fault;
   int          fails = 0, tests_run = 0, k;
   tsg_ev_t     exp_q[$];

   tsg_mem_model mem
   (
      .clk(ref_clk), .start(start), .wr_valid(wr_valid),
      .wr_offset(wr_offset), .wr_data(wr_data), .busy(mem_busy)
   );
   tsg_decode #(.NUM_IST(NI)) dut
   (
      .REF_CLK(ref_clk), .SRST(srst), .CE(ce), .LONG_MODE(long_mode),
      .MODE64(mode64), .TSS_WR_VALID(wr_valid), .TSS_WR_OFFSET(wr_offset),
      .TSS_WR_DATA(wr_data), .SP_SEL(sp_sel), .IST_SEL(ist_sel),
      .LTR_VALID(ltr_valid), .LTR_SELECTOR(ltr_sel), .LTR_DESC(ltr_desc),
      .TASK_SWITCH_REQ(ts_req), .GATE_VALID(gate_valid),
      .GATE_TABLE(gate_table), .GATE_DESC(gate_desc), .PRIV_SP(priv_sp),
      .IST_PTR(ist_ptr), .IO_PERMISSION_BITMAP_BASE(io_permission_bitmap_base), .TR_SELECTOR(tr_selector),
      .TR_DESC(tr_desc), .TR_BUSY(tr_busy), .LTR_FAULT(ltr_fault),
      .TS_ACCEPT(ts_accept), .TS_REFUSED(ts_refused),
      .GATE_DONE(gate_done), .GATE_IS_TASK(gate_is_task),
      .GATE_PRESENT(gate_present), .GATE_DPL(gate_dpl),
      .GATE_SELECTOR(gate_selector), .GATE_TABLE_OUT(gate_table_out),
      .GATE_TASK_SWITCH(gate_task_switch), .NP_FAULT(np_fault)
   );

   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // gate fields only count when a gate result is flagged
   always @(negedge ref_clk)
   begin : watch
      tsg_ev_t seen;
      tsg_ev_t want;
      seen = {gate_done ? {gate_table_out, gate_is_task, gate_present,
              gate_dpl, gate_selector} : 22'h0, gate_task_switch,
              np_fault, gate_done, ts_accept, ts_refused, ltr_fault};
      if (armed && seen[5:0] !== 6'h0)
      begin
         want = (exp_q.size() > 0) ? exp_q.pop_front() : 28'h0;
         `CHK("event", want, seen)
      end
   end

   task automatic rd(input int n);
      logic [63:0] e;
      sp_sel  = 2'(n);
      ist_sel = 3'(n);
      repeat (2) @(negedge ref_clk);
      e = (n % 4 < 3) ? {mem.img[2*(n%4)+2], mem.img[2*(n%4)+1]} : 64'h0;
      `CHK("priv_sp", e, priv_sp)
      e = (n < NI) ? {mem.img[2*n+10], mem.img[2*n+9]} : 64'h0;
      `CHK("ist_ptr", e, ist_ptr)
   endtask : rd

   task automatic load_task_register_instruction(input logic lm, input logic m64);
      logic [63:0] x;
      logic [15:0] s;
      x         = {$urandom, $urandom};
      s         = 16'($urandom);
      long_mode = lm;
      mode64    = m64;
      if (lm && !m64)
         exp_q.push_back(28'h1);
      else
      begin
         es = s;
         ed = x | (64'h1 << TSG_BUSY_BIT);
         eb = 1'b1;
      end
      ltr_valid = 1'b1;
      ltr_desc  = x;
      ltr_sel   = s;
      @(negedge ref_clk);
      `CHK("tr_selector", es, tr_selector)
      `CHK("tr_desc", ed, tr_desc)
      `CHK("tr_busy", eb, tr_busy)
   endtask : load_task_register_instruction

   task automatic tswitch(input logic lm);
      long_mode = lm;
      exp_q.push_back({24'h0, 1'b0, !lm, lm, 1'b0});
      ts_req = 1'b1;
      @(negedge ref_clk);
   endtask : tswitch

   task automatic gate(input logic [63:0] x, input logic [1:0] t);
      logic tk;
      tk = x[44:40] == TSG_TASK_GATE;
      exp_q.push_back({t, tk, x[47], x[46:45], x[31:16],
                       tk & x[47] & !long_mode, !x[47], 4'h8});
      gate_valid = 1'b1;
      gate_desc  = x;
      gate_table = t;
      @(negedge ref_clk);
   endtask : gate

   initial
   begin
      #80000;
      fails++;
      summarize();
   end

   initial
   begin
      void'($urandom(52));
      {long_mode, mode64, ltr_valid, ts_req, gate_valid, start, armed} = '0;
      {sp_sel, ist_sel, ltr_sel, ltr_desc, gate_desc, gate_table} = '0;
      {es, ed, eb} = '0;
      srst = 1'b1;
      ce   = 1'b1;
      repeat (2) @(negedge ref_clk);
      srst  = 1'b0;
      armed = 1'b1;
      `CHK("tr_busy", 1'b0, tr_busy)
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      while (mem_busy === 1'b1)
         @(negedge ref_clk);
      for (k = 0; k < 8; k++)
         rd(k);
      `CHK("io_permission_bitmap_base", mem.img[25][31:16], io_permission_bitmap_base)
      load_task_register_instruction(1'b0, 1'b0);
      load_task_register_instruction(1'b1, 1'b0);
      load_task_register_instruction(1'b1, 1'b1);
      load_task_register_instruction(1'b1, 1'b0);
      ltr_valid = 1'b0;
      tswitch(1'b0);
      tswitch(1'b1);
      ts_req = 1'b0;
      for (k = 0; k < 40; k++)
      begin
         long_mode = 1'($urandom);
         d = {$urandom, $urandom};
         if (k % 2 == 1)
            d[44:40] = TSG_TASK_GATE;
         gate(d, 2'($urandom_range(2, 0)));
      end
      gate_valid = 1'b0;
      @(negedge ref_clk);
      // frozen: a request while disabled leaves no result
      ce         = 1'b0;
      gate_valid = 1'b1;
      repeat (2) @(negedge ref_clk);
      ce         = 1'b1;
      gate_valid = 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK("pending", 0, exp_q.size())
      summarize();
   end
endmodule : tsg_decode_tb
